// File: hw/asr_ctrl.sv
`timescale 1ns/100ps
module asr_ctrl
  import asr_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // user request port
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic              req_gate_low,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  // read answer
  output logic                   rd_valid_ff,
  output logic [DATA_W-1:0]      rd_data_ff,
  // device pins
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   select_low_a,
  output logic                   select_low_b,
  output logic                   gate_n,
  output logic                   strobe_n,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0]      dq_out,
  output logic                   dq_oe
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  asr_pin_if  pv ();
  asr_state_e state_ff;
  asr_state_e nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [ADDR_W-1:0] addr_hold_ff;
  logic [DATA_W-1:0] data_hold_ff;
  logic              gate_hold_ff;
  logic              take;

  // stretched pulse when the device outputs may still be on
  function automatic logic [CNT_W-1:0] pulse_len(input logic gate_low);
    int n;
    n = WR_BASE;
    if (gate_low && WR_GATE > n) n = WR_GATE;
    if (WR_SEL > n) n = WR_SEL;
    if (WR_ADR > n) n = WR_ADR;
    // gate low: one extra strobe cycle lets the device float first
    if (gate_low) n = n + 1;
    return CNT_W'(n);
  endfunction

  // counter on the final cycle of a timed phase
  function automatic logic cnt_last(input logic [CNT_W-1:0] c);
    return (c == CNT_W'(1));
  endfunction

  // ------------------------------------------------------------
  // request acceptance
  // ------------------------------------------------------------
  assign req_ready = (state_ff == ASR_IDLE);
  assign take      = req_valid && req_ready;

  // latch request; address held stable for the whole access
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      addr_hold_ff <= '0;
      data_hold_ff <= '0;
      gate_hold_ff <= 1'b0;
    end else if (take) begin
      addr_hold_ff <= req_addr;
      data_hold_ff <= req_wdata;
      gate_hold_ff <= req_gate_low;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ASR_IDLE: begin
        if (take) begin
          nxt_state = req_write ? ASR_WSET : ASR_READ;
          nxt_cnt   = req_write ? CNT_W'(1) : CNT_W'(RD_CYC);
        end
      end
      ASR_READ: begin
        nxt_cnt = cnt_ff - CNT_W'(1);
        if (cnt_last(cnt_ff)) begin
          nxt_state = ASR_IDLE;
        end
      end
      ASR_WSET: begin
        nxt_state = ASR_WPULS;
        nxt_cnt   = pulse_len(gate_hold_ff);
      end
      ASR_WPULS: begin
        nxt_cnt = cnt_ff - CNT_W'(1);
        if (cnt_last(cnt_ff)) begin
          nxt_state = ASR_REC;
          nxt_cnt   = CNT_W'(REC_CYC);
        end
      end
      ASR_REC: begin
        nxt_cnt = cnt_ff - CNT_W'(1);
        if (cnt_last(cnt_ff)) begin
          nxt_state = ASR_IDLE;
        end
      end
      default: begin
        nxt_state = ASR_IDLE;
        nxt_cnt   = '0;
      end
    endcase
  end

  // state and counter registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_ff <= ASR_IDLE;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // ------------------------------------------------------------
  // next pin levels
  // ------------------------------------------------------------
  always_comb begin
    pv.load     = 1'b1;
    pv.addr     = take ? req_addr : addr_hold_ff;
    pv.wdata    = data_hold_ff;
    pv.sel_n    = 1'b1;
    pv.gate_n   = 1'b1;
    pv.strobe_n = 1'b1;
    pv.drive    = 1'b0;
    case (nxt_state)
      ASR_READ: begin
        pv.sel_n  = 1'b0;
        pv.gate_n = 1'b0;
      end
      ASR_WSET: begin
        // selects and gate first, address loaded on the same edge;
        // only entered on a take, so the gate follows the request itself
        pv.sel_n  = 1'b0;
        pv.gate_n = ~req_gate_low;
      end
      ASR_WPULS: begin
        // strobe low after selects: device outputs float (with gate high they were floating already)
        pv.sel_n    = 1'b0;
        pv.gate_n   = ~gate_hold_ff;
        pv.strobe_n = 1'b0;
        // gate high: device already floating, drive at once;
        // gate low: bus taken only once the device has floated
        pv.drive    = !gate_hold_ff || (state_ff == ASR_WPULS);
      end
      ASR_REC: begin
        // selects and strobe rise together; data held one more
        pv.drive = 1'b1;
      end
      default: begin
        pv.load = 1'b1;
      end
    endcase
  end

  asr_pin_reg u_pins (
    .mclk            (mclk),
    .reset           (reset),
    .p               (pv),
    .addr_ff         (mem_addr),
    .dq_out_ff       (dq_out),
    .dq_oe_ff        (dq_oe),
    .select_low_a_ff (select_low_a),
    .select_low_b_ff (select_low_b),
    .gate_n_ff       (gate_n),
    .strobe_n_ff     (strobe_n)
  );

  // ------------------------------------------------------------
  // read capture at the end of the read window
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= '0;
    end else begin
      // sampled before address moves, within output hold
      rd_valid_ff <= (state_ff == ASR_READ) && cnt_last(cnt_ff);
      if ((state_ff == ASR_READ) && cnt_last(cnt_ff)) begin
        rd_data_ff <= dq_in;
      end
    end
  end

  // recovery state keeps the next read off the bus
  // before the device may drive again

endmodule

// File: hw/asr_pkg.sv
package asr_pkg;

  // ------------------------------------------------------------
  // array geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int DATA_W = 4;

  // ------------------------------------------------------------
  // timing, slowest speed grade, in ns
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 25;
  localparam int READ_CYCLE_NS    = 15;  // read cycle, address access
  localparam int READ_OUT_HOLD_NS = 3;   // read_output_hold
  localparam int ADDR_TO_END_NS   = 10;  // address to end of write
  localparam int SEL_TO_END_NS    = 10;  // select_to_write_end
  localparam int WR_PULSE_NS      = 10;  // minimum strobe width
  localparam int STROBE_FLOAT_NS  = 4;   // strobe_to_output_float
  localparam int DATA_SETUP_NS    = 7;   // write_data_setup
  localparam int WR_RECOVER_NS    = 4;   // output from end of write

  // least times round up, never below one cycle
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RD_CYC  = min_cycles(READ_CYCLE_NS) + 1;
  localparam int WR_BASE = min_cycles(WR_PULSE_NS);
  localparam int WR_SEL  = min_cycles(SEL_TO_END_NS);
  localparam int WR_ADR  = min_cycles(ADDR_TO_END_NS);
  localparam int WR_GATE = min_cycles(STROBE_FLOAT_NS + DATA_SETUP_NS);
  localparam int REC_CYC = min_cycles(WR_RECOVER_NS);
  localparam int CNT_W   = 4;

  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    ASR_IDLE  = 5'b0_0001,
    ASR_READ  = 5'b0_0010,
    ASR_WSET  = 5'b0_0100,
    ASR_WPULS = 5'b0_1000,
    ASR_REC   = 5'b1_0000
  } asr_state_e;

endpackage

// File: hw/asr_pin_if.sv
`timescale 1ns/100ps
// pin-level values held by the pin register module
interface asr_pin_if;
  import asr_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              sel_n;
  logic              gate_n;
  logic              strobe_n;
  logic              drive;
  logic              load;
  modport ctl (output addr, wdata, sel_n, gate_n, strobe_n, drive, load);
  modport pin (input addr, wdata, sel_n, gate_n, strobe_n, drive, load);
endinterface

// File: hw/asr_pin_reg.sv
`timescale 1ns/100ps
// pin output registers: every pin level comes from a flip-flop
module asr_pin_reg
  import asr_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // sequencer values
  asr_pin_if.pin                 p,
  // device pins
  output logic [ADDR_W-1:0]      addr_ff,
  output logic [DATA_W-1:0]      dq_out_ff,
  output logic                   dq_oe_ff,
  output logic                   select_low_a_ff,
  output logic                   select_low_b_ff,
  output logic                   gate_n_ff,
  output logic                   strobe_n_ff
);

  // ------------------------------------------------------------
  // registered pins, idle state deselected and not driving
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      addr_ff         <= '0;
      dq_out_ff       <= '0;
      dq_oe_ff        <= 1'b0;
      select_low_a_ff <= 1'b1;
      select_low_b_ff <= 1'b1;
      gate_n_ff       <= 1'b1;
      strobe_n_ff     <= 1'b1;
    end else if (p.load) begin
      addr_ff         <= p.addr;
      dq_out_ff       <= p.wdata;
      dq_oe_ff        <= p.drive;
      select_low_a_ff <= p.sel_n;
      select_low_b_ff <= p.sel_n;
      gate_n_ff       <= p.gate_n;
      strobe_n_ff     <= p.strobe_n;
    end
  end

endmodule

// File: dv/asr_ctrl_props.sv
`timescale 1ns/100ps
module asr_ctrl_props
  import asr_pkg::*;
(
  // clock and reset
  input wire logic              mclk,
  input wire logic              reset,
  // request side
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire logic              req_write,
  input wire logic              req_gate_low,
  input wire logic              rd_valid_ff,
  // device pins
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic              select_low_a,
  input wire logic              select_low_b,
  input wire logic              gate_n,
  input wire logic              strobe_n,
  input wire logic              dq_oe
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);
  // accepted request
  wire take = req_valid && req_ready;
  // selected with gate low: device may be driving unless strobe is low
  wire dev_on = !select_low_a && !gate_n;
  a_sel_pair_same: assert property (select_low_a == select_low_b)
    else $error("selects differ");
  a_gate_no_drive: assert property (
    dev_on && (strobe_n || $past(strobe_n)) |-> !dq_oe)
    else $error("host drives while device may drive");
  a_strobe_in_sel: assert property (!strobe_n |-> !select_low_a)
    else $error("strobe low outside select");
  a_sel_before_strobe: assert property ($fell(strobe_n) |-> $past(!select_low_a))
    else $error("select not low before strobe");
  a_addr_held: assert property (!select_low_a && $past(!select_low_a) |-> $stable(mem_addr))
    else $error("address moved while selected");
  a_read_answer: assert property (take && !req_write |-> ##3 rd_valid_ff)
    else $error("read answer late");
  a_write_pulse: assert property (
    take && req_write && req_gate_low |-> ##2 !strobe_n ##1 !strobe_n ##1 strobe_n)
    else $error("stretched strobe pulse wrong");
  a_short_pulse: assert property (
    take && req_write && !req_gate_low |-> ##2 !strobe_n ##1 strobe_n)
    else $error("short strobe pulse wrong");
  a_gate_high_wr: assert property (take && req_write && !req_gate_low |-> ##1 gate_n[*4])
    else $error("gate low in plain write");
  a_data_release: assert property ($rose(strobe_n) |-> $past(dq_oe) ##1 !dq_oe)
    else $error("data not held then released");
endmodule
bind asr_ctrl asr_ctrl_props asr_ctrl_props_i (.mclk(mclk), .reset(reset), .req_valid(req_valid),
  .req_ready(req_ready), .req_write(req_write), .req_gate_low(req_gate_low),
  .rd_valid_ff(rd_valid_ff), .mem_addr(mem_addr), .select_low_a(select_low_a),
  .select_low_b(select_low_b), .gate_n(gate_n), .strobe_n(strobe_n), .dq_oe(dq_oe));

// File: dv/asr_sram_model.sv
`timescale 1ns/100ps
module asr_sram_model
  import asr_pkg::*;
(
  // device pins
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic              select_low_a,
  input wire logic              select_low_b,
  input wire logic              gate_n,
  input wire logic              strobe_n,
  input wire logic [DATA_W-1:0] dq_host,
  input wire logic              dq_host_oe,
  // device drive
  output logic [DATA_W-1:0]     dq_dev,
  output logic                  dev_drv
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] last_val;
  wire sel = !select_low_a && !select_low_b;
  // write only in the overlap of selects and strobe
  always @(*) begin
    if (sel && !strobe_n && dq_host_oe) mem[mem_addr] = dq_host;
  end
  // output drive, delayed to cover recovery after write end
  assign #(WR_RECOVER_NS) dev_drv = sel && !gate_n && strobe_n;
  assign #(READ_OUT_HOLD_NS) rd_word = mem[mem_addr];
  // released pins show the inverse of the last word
  always @(*) begin
    if (dev_drv) last_val = rd_word;
  end
  assign dq_dev = dev_drv ? rd_word : ~last_val;
endmodule

// File: dv/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import asr_pkg::*;
;
  logic mclk, reset, req_valid, req_write, req_gate_low, req_ready, rd_valid_ff;
  logic select_low_a, select_low_b, gate_n, strobe_n, dq_oe, dev_drv;
  logic [ADDR_W-1:0] req_addr, mem_addr;
  logic [DATA_W-1:0] req_wdata, rd_data_ff, dq_out, dq_dev;
  int num_errors = 0;
  int cmp_count = 0;
  // bus level from both drivers, a clash shows unknown
  wire [DATA_W-1:0] dq_bus = (dq_oe && dev_drv) ? {DATA_W{1'bx}} : (dq_oe ? dq_out : dq_dev);
  asr_ctrl asr_ctrl_i (.mclk(mclk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_gate_low(req_gate_low), .req_addr(req_addr),
    .req_wdata(req_wdata), .rd_valid_ff(rd_valid_ff), .rd_data_ff(rd_data_ff),
    .mem_addr(mem_addr), .select_low_a(select_low_a), .select_low_b(select_low_b),
    .gate_n(gate_n), .strobe_n(strobe_n), .dq_in(dq_bus), .dq_out(dq_out), .dq_oe(dq_oe));
  asr_sram_model asr_sram_model_i (.mem_addr(mem_addr), .select_low_a(select_low_a),
    .select_low_b(select_low_b), .gate_n(gate_n), .strobe_n(strobe_n), .dq_host(dq_out),
    .dq_host_oe(dq_oe), .dq_dev(dq_dev), .dev_drv(dev_drv));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hold the request until taken, return just after the take edge
  task automatic request(input logic wr, input logic gl, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_write = wr;
    req_gate_low = gl;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("req_ready", 14'h0001, {13'h0000, req_ready});
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
  endtask
  task automatic do_write(input logic gl, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    request(1'b1, gl, a, d);
    // gate low costs one float cycle before the bus is taken
    repeat (gl ? 2 : 1) @(posedge mclk);
    #1;
    check("write data", {8'h00, 2'b01, d}, {8'h00, strobe_n, dq_oe, dq_out});
    @(posedge mclk);
    #1;
    check("write end", {7'h00, 3'b111, d}, {7'h00, strobe_n, select_low_a, dq_oe, dq_out});
  endtask
  task automatic do_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    request(1'b0, 1'b0, a, 4'h0);
    @(posedge mclk);
    #1;
    check("read addr", a, mem_addr);
    check("rd ctl", 14'h0001, {10'h000, select_low_a, select_low_b, gate_n, strobe_n});
    // answer stands for one cycle only, two edges after the pins settle
    @(posedge mclk);
    #1;
    check("rd_valid", 14'h0001, {13'h0000, rd_valid_ff});
    check("rd_data", {10'h000, exp}, {10'h000, rd_data_ff});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_idle();
    check("idle pins", 14'h000e, {10'h000, select_low_a, gate_n, strobe_n, dq_oe});
    check("idle sel b", 14'h0001, {13'h0000, select_low_b});
  endtask
  task automatic t_corners();
    do_write(1'b0, 14'h0000, 4'h5);
    do_write(1'b1, 14'h3fff, 4'ha);
    do_write(1'b1, 14'h1555, 4'hf);
    do_read(14'h0000, 4'h5);
    do_read(14'h3fff, 4'ha);
    do_read(14'h1555, 4'hf);
  endtask
  task automatic t_back_to_back();
    do_write(1'b0, 14'h0005, 4'hc);
    do_write(1'b1, 14'h0005, 4'h3);
    do_read(14'h0005, 4'h3);
    do_read(14'h0000, 4'h5);
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #(4000 * CLK_PERIOD_NS);
    num_errors++;
    complete_run();
  end
  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_gate_low = 1'b0;
    req_addr = 14'h0000;
    req_wdata = 4'h0;
    repeat (8) @(posedge mclk);
    #1;
    reset = 1'b0;
    t_reset_idle();
    t_corners();
    t_back_to_back();
    complete_run();
  end
endmodule
